// >>> sar_pkg.sv
// Shared constants and types for the converter sequencing and readout block.
// Assumes one 200 MHz system clock; all pin inputs arrive asynchronously.
package sar_pkg;

	// ------------------------------------------------------------
	// Clock and timing figures
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;  // System clock period
	localparam int CONV_TIME_NS  = 610;   // Longest conversion interval
	localparam int ACQ_TIME_NS   = 150;   // Least acquisition interval
	localparam int BUSY_MAX_NS   = 630;   // Longest busy high phase
	localparam int RISE_MAX_NS   = 40;    // Longest start to busy delay
	localparam int RESUME_NS     = 20;    // Delay from reset release to sampling

	// Cycle counts: longest times round down, least times round up
	localparam int CONV_CYCLES     = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int BUSY_MAX_CYCLES = (BUSY_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam int RISE_MAX_CYCLES = (RISE_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam int ACQ_CYCLES      = (ACQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RESUME_CYCLES   = (RESUME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ------------------------------------------------------------
	// Result format
	// ------------------------------------------------------------
	localparam int RESULT_W   = 16;                     // Result width
	localparam int BIT_CYCLES = CONV_CYCLES / RESULT_W; // Cycles per decided bit
	localparam int CNT_W      = 8;                      // Timing counter width
	localparam int BUF_DEPTH  = 2;                      // Result buffer entries

	localparam logic [7:0]          FOLD_FILL  = 8'hFF;    // Lower pins in fold mode
	localparam logic [15:0]         SIGN_FLIP  = 16'h8000; // Two's complement <-> offset
	localparam logic [15:0]         OE_FULL    = 16'hFFFF; // All pins enabled
	localparam logic [15:0]         OE_UPPER   = 16'hFF00; // Upper pins only
	localparam logic [CNT_W-1:0]    RESUME_LAST = CNT_W'(RESUME_CYCLES - 1);
	localparam logic [CNT_W-1:0]    ACQ_DONE    = CNT_W'(ACQ_CYCLES);

	// Conversion control states
	typedef enum logic [1:0] {
		ST_RESUME,
		ST_ACQUIRE,
		ST_CONVERT
	} conv_state_e;

endpackage

// >>> result_fifo.sv
// Two-entry result buffer with valid/ready on both sides.
// Assumes the producer honours in_ready and the consumer may stall.
module result_fifo
	import sar_pkg::*;
#(
	parameter int W     = RESULT_W,
	parameter int DEPTH = BUF_DEPTH
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// Filling side
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	// Draining side
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem; // Stored words
		logic [AW-1:0]           wp;  // Write pointer
		logic [AW-1:0]           rp;  // Read pointer
		logic [AW:0]             cnt; // Words held
	} fifo_s;

	fifo_s r;
	fifo_s next_r;
	logic  push;
	logic  pop;

	// Honest flags from the count
	assign in_ready  = (r.cnt != (AW + 1)'(DEPTH));
	assign out_valid = (r.cnt != '0);
	assign out_data  = r.mem[r.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Next state: write, read, wrap pointers
	always_comb begin
		next_r = r;
		if (push) begin
			next_r.mem[r.wp] = in_data;
			next_r.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + AW'(1);
		end
		if (pop) begin
			next_r.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + AW'(1);
		end
		// Count moves only when one side acts alone
		if (push && !pop) begin
			next_r.cnt = r.cnt + (AW + 1)'(1);
		end else if (pop && !push) begin
			next_r.cnt = r.cnt - (AW + 1)'(1);
		end
	end

	// Register the state
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

endmodule

// >>> sar_sequencer.sv
// Successive-approximation engine timed by its own divider.
// Assumes sample stays stable from start until done.
module sar_sequencer
	import sar_pkg::*;
#(
	parameter int W = RESULT_W
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// Control
	input  wire logic         start,
	input  wire logic [W-1:0] sample,
	// Result
	output logic              done,
	output logic [W-1:0]      result
);

	localparam int LW         = $clog2(W) + 1;
	localparam int DONE_DELAY = CONV_CYCLES + 1;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic             run;  // Conversion running
		logic [CNT_W-1:0] cnt;  // Cycles into conversion
		logic [CNT_W-1:0] tick; // Internal bit clock divider
		logic [LW-1:0]    left; // Bits still to decide
		logic [W-1:0]     acc;  // Offset-binary approximation
		logic             done; // Completion pulse
		logic [W-1:0]     res;  // Finished result
	} seq_s;

	seq_s         r;
	seq_s         next_r;
	logic [W-1:0] target;
	logic [W-1:0] trial;

	assign done   = r.done;
	assign result = r.res;
	// Offset-binary view of the signed sample
	assign target = sample ^ W'(SIGN_FLIP);
	assign trial  = r.acc | (W'(1) << (r.left - LW'(1)));

	// Next state: one bit decided per divider period
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		if (start && !r.run) begin
			next_r.run  = 1'b1;
			next_r.cnt  = '0;
			next_r.tick = '0;
			next_r.left = LW'(W);
			next_r.acc  = '0;
		end else if (r.run) begin
			next_r.cnt = r.cnt + CNT_W'(1);
			// (RL2) internal bit clock
			if (r.tick == CNT_W'(BIT_CYCLES - 1)) begin
				next_r.tick = '0;
				if (r.left != '0) begin
					next_r.left = r.left - LW'(1);
					if (trial <= target) begin
						next_r.acc = trial;
					end
				end
			end else begin
				next_r.tick = r.tick + CNT_W'(1);
			end
			// (RL3) fixed conversion length
			if (r.cnt == CNT_W'(CONV_CYCLES - 1)) begin
				next_r.run  = 1'b0;
				next_r.done = 1'b1;
				// (RL23) back to two's complement
				next_r.res  = r.acc ^ W'(SIGN_FLIP);
			end
		end
	end

	// Register the state
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_conv_len;
		@(posedge clk) disable iff (!nrst)
		(start && !r.run) |-> ##DONE_DELAY done;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong"); // RL3

endmodule

// >>> sar_conv_ctrl.sv
// Conversion sequencing and parallel readout of a 16-bit converter.
// Assumes the host drives strobes asynchronously; NRST is the reset pin.
// Function
// (RL1) Busy high exactly while converting
// (RL2) Conversion clock comes from internal divider
// (RL3) Conversion finishes within 610 ns
// (RL4) Capture input sample at conversion start
// (RL5) Inputs isolated while conversion runs
// (RL6) Busy rises within 40 ns of start
// (RL7) Busy falls within 20 ns of end
// (RL8) Busy never high beyond 630 ns
// (RL9) Busy low lasts at least acquisition
// (RL10) Host allows 150 ns acquisition
// (RL11) Host start strobe low/high 20 ns
// (RL12) Host chip select low before start
// (RL13) Host quiet bus 40 ns after start
// (RL14) Host read strobe 50 low, 20 high
// (RL15) Result valid by busy falling edge
// (RL16) Bus released within 30 ns of read end
// (RL17) Fold select moves low byte up, ones below
// (RL18) Fold or width change shown within 30 ns
// (RL19) Host sets fold select before read
// (RL20) Reset aborts conversion, clears latches
// (RL21) Reset works regardless of chip select
// (RL22) Host uses busy fall as interrupt
// (RL23) Results coded in two's complement
// (RL24) Sampling restarts at busy or select fall
// (RL25) Host avoids reads near start edge
// (RL26) Sampling resumes 20 ns after reset
// (RL27) Result latch holds until next result
// (RL28) Start ignored while busy high
module sar_conv_ctrl
	import sar_pkg::*;
(
	// Clock and reset
	input  wire logic                CLK_SYS,
	input  wire logic                NRST,
	// Host strobes
	input  wire logic                CONVERSION_START_N,
	input  wire logic                CS_N,
	input  wire logic                RD_N,
	input  wire logic                FOLD_SELECT,
	input  wire logic                BUS_WIDTH_SELECT,
	// Digitised input level
	input  wire logic [RESULT_W-1:0] ANALOG_CODE,
	// Status
	output logic                     BUSY,
	output logic                     SAMPLING,
	output logic                     INPUT_ISOLATED,
	// Result data pins
	output logic [RESULT_W-1:0]      RESULT_DATA_PINS_O,
	output logic [RESULT_W-1:0]      RESULT_DATA_PINS_OE
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic                conv_s1;   // Start strobe sync stage 1
		logic                conv_s2;   // Start strobe sync stage 2
		logic                conv_s3;   // Start strobe previous
		logic                cs_s1;     // Select sync stage 1
		logic                cs_s2;     // Select sync stage 2
		logic                cs_s3;     // Select previous
		logic                rd_s1;     // Read sync stage 1
		logic                rd_s2;     // Read sync stage 2
		logic                fold_s1;   // Fold sync stage 1
		logic                fold_s2;   // Fold sync stage 2
		logic                width_s1;  // Width sync stage 1
		logic                width_s2;  // Width sync stage 2
		logic [RESULT_W-1:0] ana_s1;    // Input sync stage 1
		logic [RESULT_W-1:0] ana_s2;    // Input sync stage 2
		conv_state_e         state;     // Control state
		logic [CNT_W-1:0]    cnt;       // Resume/acquisition counter
		logic                busy;      // Busy pin
		logic                isolated;  // Inputs disconnected
		logic                sampling;  // Inputs tracking
		logic [RESULT_W-1:0] hold;      // Held sample
		logic                seq_start; // Start pulse to engine
		logic [RESULT_W-1:0] out_word;  // Output latch
		logic                rd_act_q;  // Read active last cycle
		logic                read_old;  // Read of the previous word
		logic [RESULT_W-1:0] data_o;    // Data pin levels
		logic [RESULT_W-1:0] data_oe;   // Data pin enables
	} ctrl_s;

	ctrl_s               r;
	ctrl_s               next_r;
	logic                rd_act;     // Select and read both low
	logic                start_edge; // Falling start strobe
	logic                cs_fall;    // Falling select
	logic                eligible;   // Conversion may begin
	logic                load;       // Latch takes a result
	logic                seq_done;   // Engine finished
	logic [RESULT_W-1:0] seq_result; // Engine result
	logic                buf_in_rdy; // Buffer has room
	logic                buf_valid;  // Buffer holds a word
	logic [RESULT_W-1:0] buf_data;   // Oldest buffered word
	logic [RESULT_W-1:0] fold_word;  // Folded view of the latch

	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	// Engine runs from its own divider
	sar_sequencer #(
		.W      (RESULT_W)
	) u_seq (
		.clk    (CLK_SYS),
		.nrst   (NRST),
		.start  (r.seq_start),
		.sample (r.hold),
		.done   (seq_done),
		.result (seq_result)
	);

	// Buffer between engine and output latch
	result_fifo #(
		.W         (RESULT_W),
		.DEPTH     (BUF_DEPTH)
	) u_buf (
		.clk       (CLK_SYS),
		.nrst      (NRST),
		.in_valid  (seq_done),
		.in_data   (seq_result),
		.in_ready  (buf_in_rdy),
		.out_valid (buf_valid),
		.out_data  (buf_data),
		.out_ready (!r.read_old)
	);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	assign rd_act     = !r.cs_s2 && !r.rd_s2;
	assign start_edge = r.conv_s3 && !r.conv_s2;
	assign cs_fall    = r.cs_s3 && !r.cs_s2;
	// (RL12) select must already be low
	assign eligible   = (r.state == ST_ACQUIRE) && (r.cnt == ACQ_DONE)
		&& !r.cs_s2 && buf_in_rdy;
	// Latch drains the buffer unless an old-word read is open
	assign load       = (r.state == ST_CONVERT) && buf_valid && !r.read_old;
	assign fold_word  = {r.out_word[7:0], FOLD_FILL};

	// Next state
	always_comb begin
		next_r = r;
		next_r.seq_start = 1'b0;
		// Two-stage synchronisers
		next_r.conv_s1  = CONVERSION_START_N;
		next_r.conv_s2  = r.conv_s1;
		next_r.conv_s3  = r.conv_s2;
		next_r.cs_s1    = CS_N;
		next_r.cs_s2    = r.cs_s1;
		next_r.cs_s3    = r.cs_s2;
		next_r.rd_s1    = RD_N;
		next_r.rd_s2    = r.rd_s1;
		next_r.fold_s1  = FOLD_SELECT;
		next_r.fold_s2  = r.fold_s1;
		next_r.width_s1 = BUS_WIDTH_SELECT;
		next_r.width_s2 = r.width_s1;
		next_r.ana_s1   = ANALOG_CODE;
		next_r.ana_s2   = r.ana_s1;
		unique case (r.state)
			// (RL26) short pause after reset release
			ST_RESUME: begin
				next_r.cnt = r.cnt + CNT_W'(1);
				if (r.cnt == RESUME_LAST) begin
					next_r.state    = ST_ACQUIRE;
					next_r.cnt      = '0;
					next_r.sampling = 1'b1;
				end
			end
			// Tracking input, waiting for a start
			ST_ACQUIRE: begin
				// (RL9) enforce least acquisition
				if (r.cnt != ACQ_DONE) begin
					next_r.cnt = r.cnt + CNT_W'(1);
				end
				// (RL24) select fall reopens sampling
				if (cs_fall) begin
					next_r.sampling = 1'b1;
				end
				// (RL6) busy on start edge
				if (start_edge && eligible) begin
					next_r.state     = ST_CONVERT;
					next_r.busy      = 1'b1;
					// (RL5) inputs cut off
					next_r.isolated  = 1'b1;
					next_r.sampling  = 1'b0;
					// (RL4) capture the sample
					next_r.hold      = r.ana_s2;
					next_r.seq_start = 1'b1;
				end
			end
			// (RL28) start edges ignored here
			// (RL8) busy bounded by engine length
			ST_CONVERT: begin
				// (RL7) busy drops as result lands
				// (RL15) result latched as busy falls
				// (RL27) latch written only here
				if (load) begin
					next_r.out_word = buf_data;
					// (RL1) busy clears with state
					next_r.busy     = 1'b0;
					next_r.state    = ST_ACQUIRE;
					next_r.cnt      = '0;
					// (RL5) inputs rejoin with busy low
					next_r.isolated = 1'b0;
					// (RL24) sampling restarts if selected
					next_r.sampling = !r.cs_s2;
				end
			end
		endcase
		// A read opened while idle guards the word it is reading
		next_r.rd_act_q = rd_act;
		if (!rd_act) begin
			next_r.read_old = 1'b0;
		end else if (!r.rd_act_q && !r.busy) begin
			next_r.read_old = 1'b1;
		end
		// (RL16) enables follow select and read
		if (rd_act) begin
			next_r.data_oe = r.width_s2 ? OE_UPPER : OE_FULL;
		end else begin
			next_r.data_oe = '0;
		end
		// (RL17) fold or full word
		// (RL18) mux follows the fold select
		next_r.data_o = r.fold_s2 ? fold_word : r.out_word;
	end

	// (RL20) reset aborts and clears
	// (RL21) reset ignores select
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			r <= '0;
			// Start, select and read synchronisers start idle high: no false edge or read after reset
			r.conv_s1 <= 1'b1;
			r.conv_s2 <= 1'b1;
			r.conv_s3 <= 1'b1;
			r.cs_s1   <= 1'b1;
			r.cs_s2   <= 1'b1;
			r.cs_s3   <= 1'b1;
			r.rd_s1   <= 1'b1;
			r.rd_s2   <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from flops
	assign BUSY                = r.busy;
	assign SAMPLING            = r.sampling;
	assign INPUT_ISOLATED      = r.isolated;
	assign RESULT_DATA_PINS_O  = r.data_o;
	assign RESULT_DATA_PINS_OE = r.data_oe;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!NRST);

	// Helper counters for long phases
	logic [CNT_W-1:0] busy_len;
	logic [CNT_W-1:0] low_len;
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			busy_len <= '0;
			low_len  <= '0;
		end else begin
			busy_len <= r.busy ? busy_len + CNT_W'(1) : '0;
			low_len  <= (r.busy || low_len == '1) ? (r.busy ? '0 : low_len) : low_len + CNT_W'(1);
		end
	end

	sequence s_start_edge;
		r.conv_s3 && !r.conv_s2;
	endsequence

	sequence s_read_end;
		RD_N || CS_N;
	endsequence

	property p_busy_rise;
		s_start_edge and eligible |=> BUSY;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy late"); // RL6

	property p_busy_level;
		BUSY == (r.state == ST_CONVERT);
	endproperty
	a_busy_level: assert property (p_busy_level) else $error("busy mismatch"); // RL1

	property p_busy_max;
		busy_len <= CNT_W'(BUSY_MAX_CYCLES);
	endproperty
	a_busy_max: assert property (p_busy_max) else $error("busy too long"); // RL8

	property p_acq;
		$rose(BUSY) |-> low_len >= CNT_W'(ACQ_CYCLES);
	endproperty
	a_acq: assert property (p_acq) else $error("acquisition too short"); // RL9

	property p_release;
		s_read_end |-> ##3 (RESULT_DATA_PINS_OE == '0);
	endproperty
	a_release: assert property (p_release) else $error("bus not released"); // RL16

	property p_fold;
		(RESULT_DATA_PINS_OE != '0) && $past(r.fold_s2) |-> RESULT_DATA_PINS_O == $past(fold_word);
	endproperty
	a_fold: assert property (p_fold) else $error("fold data wrong"); // RL17

	property p_hold;
		!load |=> $stable(r.out_word);
	endproperty
	a_hold: assert property (p_hold) else $error("latch changed"); // RL27

	property p_ignore;
		BUSY and s_start_edge |=> $stable(r.hold);
	endproperty
	a_ignore: assert property (p_ignore) else $error("restart while busy"); // RL28

	property p_msb;
		$fell(BUSY) |-> r.out_word == $past(buf_data);
	endproperty
	a_msb: assert property (p_msb) else $error("result late"); // RL15

	property p_isolate;
		INPUT_ISOLATED |-> !SAMPLING && BUSY;
	endproperty
	a_isolate: assert property (p_isolate) else $error("inputs not isolated"); // RL5

endmodule

// >>> host_model.sv
// Host model: drives the converter's start, select, read and fold strobes.
// Assumes one caller at a time and a 200 MHz clock shared with the device.
module host_model
	import sar_pkg::*;
(
	// Clock and status
	input  wire logic                clk,
	input  wire logic                busy,
	// Strobes towards the converter
	output logic                     start_n,
	output logic                     cs_n,
	output logic                     rd_n,
	output logic                     fold,
	output logic                     width8,
	// Data pins
	input  wire logic [RESULT_W-1:0] pins_o,
	input  wire logic [RESULT_W-1:0] pins_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle levels: nothing selected, no read, full word
	initial begin
		start_n = 1'b1;
		cs_n    = 1'b1;
		rd_n    = 1'b1;
		fold    = 1'b0;
		width8  = 1'b0;
	end

	task automatic convert(input logic sel_n, output logic seen);
		@(posedge clk) cs_n <= sel_n;
		@(posedge clk) start_n <= 1'b0;
		repeat (8) @(posedge clk);
		seen = busy;
		start_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	// Drop chip select between frames
	task automatic deselect();
		@(posedge clk) cs_n <= 1'b1;
	endtask

	// read low 90 ns, fold set first
	task automatic read(input logic f, input logic w,
		output logic [15:0] d, output logic [15:0] d2,
		output logic [15:0] oe, output logic [15:0] off);
		@(posedge clk) begin
			cs_n   <= 1'b0;
			fold   <= f;
			width8 <= w;
		end
		@(posedge clk) rd_n <= 1'b0;
		repeat (12) @(posedge clk);
		d    = pins_o;
		oe   = pins_oe;
		fold <= ~f;
		repeat (6) @(posedge clk);
		d2   = pins_o;
		rd_n <= 1'b1;
		repeat (6) @(posedge clk);
		off = pins_oe;
	endtask
endmodule

// >>> testbench.sv
// Testbench for the converter sequencing and parallel readout block.
// Assumes the host model owns all strobes; the bench drives reset and code.
module testbench
	import sar_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic                CLK_SYS;
	logic                NRST;
	logic [RESULT_W-1:0] ANALOG_CODE;
	logic                start_n, cs_n, rd_n, fold, width8;
	logic                BUSY, SAMPLING, INPUT_ISOLATED;
	logic [RESULT_W-1:0] pins_o, pins_oe;
	int                  error_cnt, total_checks;
	int                  hi_cnt, lo_cnt, last_hi, min_lo, iso_gap;
	logic [15:0]         exp_lat;  // Result the latch should hold
	logic [15:0]         lfsr;     // Random code source
	logic [15:0]         exp_q[$]; // Codes awaiting conversion

	// ------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------
	sar_conv_ctrl DUT (.CLK_SYS(CLK_SYS), .NRST(NRST), .CONVERSION_START_N(start_n),
		.CS_N(cs_n), .RD_N(rd_n), .FOLD_SELECT(fold), .BUS_WIDTH_SELECT(width8),
		.ANALOG_CODE(ANALOG_CODE), .BUSY(BUSY), .SAMPLING(SAMPLING),
		.INPUT_ISOLATED(INPUT_ISOLATED), .RESULT_DATA_PINS_O(pins_o),
		.RESULT_DATA_PINS_OE(pins_oe));
	host_model host (.clk(CLK_SYS), .busy(BUSY), .start_n(start_n), .cs_n(cs_n),
		.rd_n(rd_n), .fold(fold), .width8(width8), .pins_o(pins_o), .pins_oe(pins_oe));

	// 200 MHz clock
	always #2.5 CLK_SYS = ~CLK_SYS;

	// Busy high and low run lengths, isolation gaps
	always @(posedge CLK_SYS) begin
		if (BUSY === 1'b1) begin
			hi_cnt <= hi_cnt + 1;
			if (lo_cnt != 0 && lo_cnt < min_lo) min_lo <= lo_cnt;
			lo_cnt <= 0;
			if (INPUT_ISOLATED !== 1'b1) iso_gap <= iso_gap + 1;
		end else begin
			lo_cnt <= lo_cnt + 1;
			if (hi_cnt != 0) last_hi <= hi_cnt;
			hi_cnt <= 0;
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Pin image of the latch for a fold setting
	function automatic logic [15:0] fmt(input logic f);
		return f ? {exp_lat[7:0], 8'hFF} : exp_lat;
	endfunction

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Wait, bounded, for busy to drop
	task automatic wait_idle();
		int n;
		n = 0;
		while (BUSY !== 1'b0 && n < 300) begin
			@(posedge CLK_SYS);
			n++;
		end
		if (n >= 300) chk("busy_timeout", 16'h0000, 16'h0001);
		repeat (2) @(posedge CLK_SYS);
	endtask

	// One conversion with chip select low
	task automatic run_conv(input logic [15:0] code);
		logic b;
		ANALOG_CODE <= code;
		exp_q.push_back(code);
		repeat (3) @(posedge CLK_SYS);
		host.convert(1'b0, b);
		chk("busy_rise", 16'h0001, {15'h0000, b});
		wait_idle();
		chk("busy_len", 16'h0001, {15'h0000, last_hi <= 126});
		chk("sampling", 16'h0001, {15'h0000, SAMPLING});
		chk("iso_end", 16'h0000, {15'h0000, INPUT_ISOLATED});
		exp_lat = exp_q.pop_front();
	endtask

	// Read one word, fold flipped mid-read
	task automatic read_chk(input logic f, input logic w);
		logic [15:0] d, d2, oe, off, e_oe;
		e_oe = w ? 16'hFF00 : 16'hFFFF;
		host.read(f, w, d, d2, oe, off);
		chk("oe", e_oe, oe);
		chk("data", fmt(f) & e_oe, d & e_oe);
		chk("data_fold", fmt(!f) & e_oe, d2 & e_oe);
		chk("oe_off", 16'h0000, off);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic b;
		CLK_SYS = 1'b0;
		NRST = 1'b0;
		ANALOG_CODE = 16'h0000;
		{hi_cnt, lo_cnt, last_hi, iso_gap, error_cnt, total_checks} = '0;
		min_lo = 1000;
		exp_lat = 16'h0000;
		lfsr = 16'h0056;
		repeat (2) @(posedge CLK_SYS);
		NRST <= 1'b1;
		repeat (40) @(posedge CLK_SYS);
		// Codes 8000 and 7FFF, then random codes, every fold and width mode
		for (int i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			run_conv(i == 0 ? 16'h8000 : (i == 1 ? 16'h7FFF : lfsr));
			read_chk(i[0], i[1]);
			repeat (32) @(posedge CLK_SYS);
		end
		chk("busy_low", 16'h0001, {15'h0000, min_lo >= 30});
		chk("isolated", 16'h0000, iso_gap[15:0]);
		$display("test conversions done");
		// Start with select high is refused, latch holds
		ANALOG_CODE <= 16'h1234;
		host.convert(1'b1, b);
		chk("start_cs_high", 16'h0000, {15'h0000, b});
		read_chk(1'b0, 1'b0);
		$display("test refused start done");
		// Start during busy is ignored
		repeat (32) @(posedge CLK_SYS);
		run_conv(16'h00A5);
		repeat (32) @(posedge CLK_SYS);
		ANALOG_CODE <= 16'hC3C3;
		repeat (3) @(posedge CLK_SYS);
		host.convert(1'b0, b);
		repeat (40) @(posedge CLK_SYS);
		ANALOG_CODE <= 16'h5A5A;
		host.convert(1'b0, b);
		wait_idle();
		chk("restart_len", 16'h0001, {15'h0000, last_hi <= 126});
		exp_lat = 16'hC3C3;
		read_chk(1'b0, 1'b0);
		$display("test busy start done");
		// Reset mid conversion with select high
		repeat (32) @(posedge CLK_SYS);
		ANALOG_CODE <= 16'h0F0F;
		repeat (3) @(posedge CLK_SYS);
		host.convert(1'b0, b);
		repeat (30) @(posedge CLK_SYS);
		host.deselect();
		NRST <= 1'b0;
		repeat (4) @(posedge CLK_SYS);
		chk("rst_busy", 16'h0000, {15'h0000, BUSY});
		chk("rst_pins", 16'h0000, pins_o | pins_oe);
		chk("rst_iso", 16'h0000, {15'h0000, INPUT_ISOLATED});
		NRST <= 1'b1;
		repeat (7) @(posedge CLK_SYS);
		#1;
		chk("resume", 16'h0001, {15'h0000, SAMPLING});
		repeat (34) @(posedge CLK_SYS);
		exp_lat = 16'h0000;
		read_chk(1'b0, 1'b0);
		run_conv(16'hFEDC);
		read_chk(1'b1, 1'b0);
		$display("test reset done");
		test_done();
	end

	// Watchdog well past the expected run length
	initial begin
		repeat (20000) @(posedge CLK_SYS);
		error_cnt++;
		test_done();
	end
endmodule
